/* rac_ctrl.sv */
// rtc reset register, second counter, tick sources and alarm with axi4-lite slave
// Functional notes
// - second counter from 32.768 khz gives 1 hz
// - source select: alarm, 1 hz, 16 hz, none
// - clear request write 1 sampled on slow clock
// - clear request reads 1 until done
// - alarm init loads 00:00, date 01, sunday
// - 1 hz event coincides with second increment
// - first tick one second after counter clear
// - run disable stops time, counter keeps going
// - page bit selects alarm bank
// - event gives one slow-cycle low pulse on both
// - alarm fires when minute hour date weekday match
// - time writes take effect at slow clock edge
// - adjust: clear seconds, carry when 30 or more
`timescale 1ns/1ps
`include "rac_params.svh"

module rac_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic low_speed_clock,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic rtc_irq_line_n,
	output logic alarm_pin_n
);

	// ----------------------------------------
	// address decoding
	// ----------------------------------------
	function automatic rac_pkg::rac_reg_t reg_dec(input logic [7:0] a);
		case (a)
			`RAC_OFF_RESET: reg_dec = rac_pkg::RAC_REG_RESET;
			`RAC_OFF_PAGE: reg_dec = rac_pkg::RAC_REG_PAGE;
			`RAC_OFF_SEC, `RAC_OFF_MIN, `RAC_OFF_HOUR, `RAC_OFF_WDAY,
			`RAC_OFF_DATE: reg_dec = rac_pkg::RAC_REG_FIELD;
			default: reg_dec = rac_pkg::RAC_REG_NONE;
		endcase
	endfunction : reg_dec

	function automatic logic [2:0] fld_idx(input logic [7:0] a);
		fld_idx = 3'((a - `RAC_OFF_SEC) >> 2);
	endfunction : fld_idx

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic ls_prev_q;
	logic ls_tick;
	logic sec_tick;
	logic hz16_tick;
	logic clear_done;
	logic aw_got_q;
	logic w_got_q;
	logic [7:0] awaddr_q;
	logic [7:0] wdata_q;
	logic wstrb_q;
	logic wr_do;
	logic wr_reset;
	logic wr_page;
	logic wr_field;
	logic [2:0] wr_idx;
	logic one_off_q;
	logic sixteen_off_q;
	logic clear_req_q;
	logic irq_en_q;
	logic adjust_q;
	logic run_en_q;
	logic alarm_en_q;
	logic page_q;
	logic match;
	logic match_prev_q;
	logic event_now;
	rac_pkg::rac_src_t src;
	rac_pkg::rac_field_t time_q [0:`RAC_NUM_FIELDS-1];
	rac_pkg::rac_field_t pend_val_q [0:`RAC_NUM_FIELDS-1];
	rac_pkg::rac_field_t next_t [0:`RAC_NUM_FIELDS-1];
	rac_pkg::rac_field_t alm_q [1:`RAC_NUM_FIELDS-1];
	logic [`RAC_NUM_FIELDS-1:0] pend_q;
	logic car_min;
	logic car_hour;
	logic car_day;
	logic [31:0] rd_val;
	logic [2:0] rd_idx;

	// inputs are synchronous, so a single previous sample suffices
	assign ls_tick = low_speed_clock & ~ls_prev_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ls_prev_q <= 1'b0;
		end else if (clk_en) begin
			ls_prev_q <= low_speed_clock;
		end
	end

	rac_sec_counter u_sec (
		.aclk(aclk),
		.aresetn(aresetn),
		.clk_en(clk_en),
		.ls_tick(ls_tick),
		.clear_req(clear_req_q),
		.sec_tick(sec_tick),
		.hz16_tick(hz16_tick),
		.clear_done(clear_done)
	);

	// ----------------------------------------
	// axi4-lite write channel
	// ----------------------------------------
	assign wr_do = aw_got_q & w_got_q & ~s_axi_bvalid;
	assign wr_reset = wr_do & wstrb_q & (reg_dec(awaddr_q) == rac_pkg::RAC_REG_RESET);
	assign wr_page = wr_do & wstrb_q & (reg_dec(awaddr_q) == rac_pkg::RAC_REG_PAGE);
	assign wr_field = wr_do & wstrb_q & (reg_dec(awaddr_q) == rac_pkg::RAC_REG_FIELD);
	assign wr_idx = fld_idx(awaddr_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RAC_RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q <= 8'h00;
			wstrb_q <= 1'b0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata[7:0];
				wstrb_q <= s_axi_wstrb[0];
			end
			s_axi_awready <= ~aw_got_q & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready <= ~w_got_q & ~(s_axi_wvalid & s_axi_wready);
			if (wr_do) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (reg_dec(awaddr_q) == rac_pkg::RAC_REG_NONE) ?
					`RAC_RESP_SLVERR : `RAC_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// reset_control_reg
	// ----------------------------------------
	// only a written 1 acts on the request bits, so a stale readback cannot retrigger
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			one_off_q <= `RAC_RST_ONE_HZ_OFF;
			sixteen_off_q <= `RAC_RST_SIXTEEN_HZ_OFF;
			clear_req_q <= 1'b0;
		end else if (clk_en) begin
			if (wr_reset) begin
				one_off_q <= wdata_q[`RAC_BIT_ONE_HZ_OFF];
				sixteen_off_q <= wdata_q[`RAC_BIT_SIXTEEN_HZ_OFF];
			end
			if (wr_reset && wdata_q[`RAC_BIT_CLEAR_REQ]) begin
				clear_req_q <= 1'b1;
			end else if (clear_done) begin
				clear_req_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// page_control_reg
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_en_q <= 1'b0;
			adjust_q <= 1'b0;
			run_en_q <= 1'b0;
			alarm_en_q <= 1'b0;
			page_q <= 1'b0;
		end else if (clk_en) begin
			if (wr_page) begin
				irq_en_q <= wdata_q[`RAC_BIT_IRQ_EN];
				run_en_q <= wdata_q[`RAC_BIT_RUN_EN];
				alarm_en_q <= wdata_q[`RAC_BIT_ALARM_EN];
				page_q <= wdata_q[`RAC_BIT_PAGE];
			end
			if (wr_page && wdata_q[`RAC_BIT_ADJUST]) begin
				adjust_q <= 1'b1;
			end else if (sec_tick && run_en_q) begin
				adjust_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// time keeping
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < `RAC_NUM_FIELDS; i++) begin
			next_t[i] = time_q[i];
		end
		car_min = 1'b0;
		car_hour = 1'b0;
		car_day = 1'b0;
		if (sec_tick && run_en_q) begin
			if (adjust_q) begin
				next_t[0] = 7'h00;
				car_min = (time_q[0] >= `RAC_ADJ_HALF);
			end else if (time_q[0] == `RAC_SEC_MAX) begin
				next_t[0] = 7'h00;
				car_min = 1'b1;
			end else begin
				next_t[0] = time_q[0] + 7'h01;
			end
		end
		if (car_min) begin
			car_hour = (time_q[1] == `RAC_MIN_MAX);
			next_t[1] = car_hour ? 7'h00 : time_q[1] + 7'h01;
		end
		if (car_hour) begin
			car_day = (time_q[2] == `RAC_HOUR_MAX);
			next_t[2] = car_day ? 7'h00 : time_q[2] + 7'h01;
		end
		if (car_day) begin
			next_t[3] = (time_q[3] == `RAC_WDAY_MAX) ? 7'h00 : time_q[3] + 7'h01;
			next_t[4] = (time_q[4] == `RAC_DATE_MAX) ? `RAC_DATE_MIN : time_q[4] + 7'h01;
		end
	end

	// writes are held and land on the next slow clock edge
	genvar g;
	generate
		for (g = 0; g < `RAC_NUM_FIELDS; g++) begin : g_fld
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pend_q[g] <= 1'b0;
					pend_val_q[g] <= 7'h00;
					time_q[g] <= (g == 4) ? `RAC_DATE_MIN : 7'h00;
				end else if (clk_en) begin
					if (wr_field && !page_q && wr_idx == 3'(g)) begin
						pend_q[g] <= 1'b1;
						pend_val_q[g] <= wdata_q[6:0];
					end else if (ls_tick) begin
						pend_q[g] <= 1'b0;
					end
					if (ls_tick) begin
						time_q[g] <= pend_q[g] ? pend_val_q[g] : next_t[g];
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// alarm bank
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alm_q[1] <= `RAC_ALM_INIT_MIN;
			alm_q[2] <= `RAC_ALM_INIT_HOUR;
			alm_q[3] <= `RAC_ALM_INIT_WDAY;
			alm_q[4] <= `RAC_ALM_INIT_DATE;
		end else if (clk_en) begin
			if (wr_reset && wdata_q[`RAC_BIT_ALARM_INIT]) begin
				alm_q[1] <= `RAC_ALM_INIT_MIN;
				alm_q[2] <= `RAC_ALM_INIT_HOUR;
				alm_q[3] <= `RAC_ALM_INIT_WDAY;
				alm_q[4] <= `RAC_ALM_INIT_DATE;
			end else if (wr_field && page_q && wr_idx != 3'h0) begin
				alm_q[wr_idx] <= wdata_q[6:0];
			end
		end
	end

	// ----------------------------------------
	// event source and output pulse
	// ----------------------------------------
	assign match = (alm_q[1] == time_q[1]) & (alm_q[2] == time_q[2]) &
		(alm_q[3] == time_q[3]) & (alm_q[4] == time_q[4]);
	assign src = rac_pkg::src_sel(one_off_q, sixteen_off_q, alarm_en_q);

	// alarm fires on the match edge only, not for the whole matching minute
	always_comb begin
		unique case (src)
			rac_pkg::RAC_SRC_ALARM: event_now = match & ~match_prev_q;
			rac_pkg::RAC_SRC_1HZ: event_now = sec_tick;
			rac_pkg::RAC_SRC_16HZ: event_now = hz16_tick;
			rac_pkg::RAC_SRC_NONE: event_now = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_prev_q <= 1'b0;
			rtc_irq_line_n <= 1'b1;
			alarm_pin_n <= 1'b1;
		end else if (clk_en && ls_tick) begin
			match_prev_q <= match;
			rtc_irq_line_n <= ~(event_now & irq_en_q);
			alarm_pin_n <= ~(event_now & irq_en_q);
		end
	end

	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------
	assign rd_idx = fld_idx(s_axi_araddr);

	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (reg_dec(s_axi_araddr))
			rac_pkg::RAC_REG_RESET: rd_val[7:0] = {one_off_q, sixteen_off_q, clear_req_q,
				5'h00};
			rac_pkg::RAC_REG_PAGE: rd_val[7:0] = {irq_en_q, 2'h0, adjust_q, run_en_q,
				alarm_en_q, 1'b0, page_q};
			rac_pkg::RAC_REG_FIELD: begin
				if (!page_q) begin
					rd_val[6:0] = time_q[rd_idx];
				end else if (rd_idx != 3'h0) begin
					rd_val[6:0] = alm_q[rd_idx];
				end
			end
			rac_pkg::RAC_REG_NONE: rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RAC_RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= (reg_dec(s_axi_araddr) == rac_pkg::RAC_REG_NONE) ?
					`RAC_RESP_SLVERR : `RAC_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule : rac_ctrl

/* rac_ctrl_checker.sv */
// concurrent checks on the ports of rac_ctrl
`timescale 1ns/1ps

module rac_ctrl_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic low_speed_clock,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rtc_irq_line_n,
	input wire logic alarm_pin_n
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic ls_q;
	logic [3:0] since_q;
	logic aw_q;
	logic w_q;
	// cycles since the slow clock rose, saturating so it never wraps
	always_ff @(posedge aclk) begin
		ls_q <= low_speed_clock;
		if (!aresetn) since_q <= 4'hF;
		else if (low_speed_clock && !ls_q) since_q <= 4'h0;
		else if (since_q != 4'hF) since_q <= since_q + 4'h1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || (s_axi_bvalid && s_axi_bready)) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) aw_q <= 1'b1;
			if (s_axi_wvalid && s_axi_wready) w_q <= 1'b1;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_pins_equal; rtc_irq_line_n == alarm_pin_n; endproperty
	a_pins_equal: assert property (p_pins_equal) else $error("irq and alarm pin differ");
	property p_fall_tick; $fell(rtc_irq_line_n) |-> since_q < 4'h4; endproperty
	a_fall_tick: assert property (p_fall_tick) else $error("pulse start off tick");
	property p_rise_tick; $rose(rtc_irq_line_n) |-> since_q < 4'h4; endproperty
	a_rise_tick: assert property (p_rise_tick) else $error("pulse end off tick");
	property p_low_span; $fell(rtc_irq_line_n) |-> (!rtc_irq_line_n) [*4]; endproperty
	a_low_span: assert property (p_low_span) else $error("pulse too short");
	property p_b_after; $rose(s_axi_bvalid) |-> aw_q && w_q; endproperty
	a_b_after: assert property (p_b_after) else $error("response before both items");
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write response late");
	property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read data late");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
	a_r_upper: assert property (p_r_upper) else $error("upper read bits set");
	c_pulse: cover property ($fell(rtc_irq_line_n));
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : rac_ctrl_checker

bind rac_ctrl rac_ctrl_checker u_chk (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
	.low_speed_clock(low_speed_clock), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.rtc_irq_line_n(rtc_irq_line_n), .alarm_pin_n(alarm_pin_n));

/* rac_params.svh */
// constants for the rtc alarm and tick control block
`ifndef RAC_PARAMS_SVH
`define RAC_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RAC_OFF_RESET 8'h00
`define RAC_OFF_PAGE 8'h04
`define RAC_OFF_SEC 8'h08
`define RAC_OFF_MIN 8'h0C
`define RAC_OFF_HOUR 8'h10
`define RAC_OFF_WDAY 8'h14
`define RAC_OFF_DATE 8'h18

// ----------------------------------------
// reset_control_reg fields
// ----------------------------------------
`define RAC_BIT_ONE_HZ_OFF 7
`define RAC_BIT_SIXTEEN_HZ_OFF 6
`define RAC_BIT_CLEAR_REQ 5
`define RAC_BIT_ALARM_INIT 4
`define RAC_RST_ONE_HZ_OFF 1'b1
`define RAC_RST_SIXTEEN_HZ_OFF 1'b1

// ----------------------------------------
// page_control_reg fields
// ----------------------------------------
`define RAC_BIT_IRQ_EN 7
`define RAC_BIT_ADJUST 4
`define RAC_BIT_RUN_EN 3
`define RAC_BIT_ALARM_EN 2
`define RAC_BIT_PAGE 0

// ----------------------------------------
// time fields, binary coded
// ----------------------------------------
`define RAC_NUM_FIELDS 5
`define RAC_SEC_MAX 7'h3B
`define RAC_MIN_MAX 7'h3B
`define RAC_HOUR_MAX 7'h17
`define RAC_WDAY_MAX 7'h06
`define RAC_DATE_MAX 7'h1F
`define RAC_DATE_MIN 7'h01
`define RAC_ADJ_HALF 7'h1E
`define RAC_ALM_INIT_MIN 7'h00
`define RAC_ALM_INIT_HOUR 7'h00
`define RAC_ALM_INIT_DATE 7'h01
`define RAC_ALM_INIT_WDAY 7'h00

// ----------------------------------------
// second counter on the 32.768 khz clock
// ----------------------------------------
`define RAC_CNT_W 15
`define RAC_CNT_WRAP 15'h7FFF
`define RAC_SUB_WRAP 11'h7FF

// ----------------------------------------
// bus responses
// ----------------------------------------
`define RAC_RESP_OKAY 2'h0
`define RAC_RESP_SLVERR 2'h2

`endif

/* rac_pkg.sv */
// types for the rtc alarm and tick control block
package rac_pkg;

	typedef logic [6:0] rac_field_t;

	typedef enum {
		RAC_SRC_NONE,
		RAC_SRC_ALARM,
		RAC_SRC_1HZ,
		RAC_SRC_16HZ
	} rac_src_t;

	typedef enum {
		RAC_REG_RESET,
		RAC_REG_PAGE,
		RAC_REG_FIELD,
		RAC_REG_NONE
	} rac_reg_t;

	function automatic rac_src_t src_sel(input logic one_off, input logic sixteen_off,
			input logic alarm_en);
		unique case ({one_off, sixteen_off, alarm_en})
			3'b111: src_sel = RAC_SRC_ALARM;
			3'b010: src_sel = RAC_SRC_1HZ;
			3'b100: src_sel = RAC_SRC_16HZ;
			default: src_sel = RAC_SRC_NONE;
		endcase
	endfunction : src_sel

endpackage : rac_pkg

/* rac_sec_counter.sv */
// second counter prescaler running on low speed clock ticks
`timescale 1ns/1ps
`include "rac_params.svh"

module rac_sec_counter (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic ls_tick,
	input wire logic clear_req,
	output logic sec_tick,
	output logic hz16_tick,
	output logic clear_done
);
	logic [`RAC_CNT_W-1:0] cnt_q;

	// clear is sampled only on a low speed tick
	assign clear_done = ls_tick & clear_req;
	assign sec_tick = ls_tick & ~clear_req & (cnt_q == `RAC_CNT_WRAP);
	assign hz16_tick = ls_tick & ~clear_req & (cnt_q[10:0] == `RAC_SUB_WRAP);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
		end else if (clk_en && ls_tick) begin
			if (clear_req) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + `RAC_CNT_W'(1);
			end
		end
	end

endmodule : rac_sec_counter

/* rac_tb.sv */
// self-checking bench for rac_ctrl
`timescale 1ns/1ps
`include "rac_params.svh"

module tb;
	localparam int HALF = 3;
	localparam logic [1:0] OK = `RAC_RESP_OKAY;
	localparam logic [1:0] ER = `RAC_RESP_SLVERR;
	logic aclk = 0, aresetn = 0, clk_en = 1, ls = 0, irq_q = 1;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 0;
	logic awready, wready, bvalid, arready, rvalid, irq_n, alm_n;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int error_cnt = 0, n_checks = 0, fall_cnt = 0;
	int tm[4], am[4];
	int lim[4] = '{60, 24, 7, 31};
	logic [2:0] cmb[4] = '{3'b100, 3'b000, 3'b010, 3'b111};

	rac_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .low_speed_clock(ls),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .rtc_irq_line_n(irq_n),
		.alarm_pin_n(alm_n));

	initial forever #4 aclk = ~aclk;
	always @(posedge aclk) begin
		irq_q <= irq_n;
		if (irq_q === 1'b1 && irq_n === 1'b0) fall_cnt <= fall_cnt + 1;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic end_sim;
		if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_sim
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: resp %h expected %h", $time, got, exp);
		end
	endtask : chk_resp
	// slow clock only moves here, so bus work sees a frozen time base
	task automatic ticks(input int n);
		repeat (n) begin
			repeat (HALF) @(posedge aclk);
			ls <= 1'b1;
			repeat (HALF) @(posedge aclk);
			ls <= 1'b0;
		end
	endtask : ticks
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw_ok = 1'b0;
		logic w_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h000000, d};
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		chk_resp(bresp, er);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		chk_val(rdata, e);
		chk_resp(rresp, er);
		rready <= 1'b0;
	endtask : rd
	function automatic logic [7:0] fa(input int i);
		return `RAC_OFF_MIN + 8'(4 * i);
	endfunction : fa

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial begin
		repeat (80000) @(posedge aclk);
		error_cnt++;
		end_sim();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(14425));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`RAC_OFF_RESET, 32'h000000C0, OK);
		rd(`RAC_OFF_PAGE, 32'h0, OK);
		rd(8'h40, 32'h0, ER);
		wr(8'h40, 8'h55, ER);
		rd(8'h02, 32'h0, ER);
		wr(`RAC_OFF_PAGE, 8'h08, OK);
		for (int i = 0; i < 4; i++) begin
			tm[i] = $urandom % lim[i] + ((i == 3) ? 1 : 0);
			wr(fa(i), 8'(tm[i]), OK);
		end
		rd(fa(0), 32'h0, OK);
		ticks(1);
		for (int i = 0; i < 4; i++) rd(fa(i), 32'(tm[i]), OK);
		for (int i = 0; i < 4; i++) rd(fa(i), 32'(tm[i]), OK);
		wr(`RAC_OFF_PAGE, 8'h09, OK);
		for (int i = 0; i < 4; i++) begin
			am[i] = $urandom % lim[i] + ((i == 3) ? 1 : 0);
			wr(fa(i), 8'(am[i]), OK);
		end
		for (int i = 0; i < 4; i++) rd(fa(i), 32'(am[i]), OK);
		wr(`RAC_OFF_RESET, 8'hD0, OK);
		am = '{0, 0, 0, 1};
		for (int i = 0; i < 4; i++) rd(fa(i), 32'(am[i]), OK);
		rd(`RAC_OFF_SEC, 32'h0, OK);
		rd(`RAC_OFF_RESET, 32'h000000C0, OK);
		// alarm one minute ahead, armed in order, then time moved onto it
		for (int i = 0; i < 4; i++) begin
			am[i] = (i == 0) ? (tm[0] + 1) % 60 : tm[i];
			wr(fa(i), 8'(am[i]), OK);
		end
		wr(`RAC_OFF_PAGE, 8'h0D, OK);
		wr(`RAC_OFF_PAGE, 8'h8D, OK);
		wr(`RAC_OFF_PAGE, 8'h8C, OK);
		fall_cnt = 0;
		ticks(3);
		chk_val(32'(fall_cnt), 32'h0);
		wr(fa(0), 8'(am[0]), OK);
		ticks(3);
		chk_val(32'(fall_cnt), 32'h1);
		wr(`RAC_OFF_PAGE, 8'h0C, OK);
		wr(`RAC_OFF_RESET, 8'hE0, OK);
		rd(`RAC_OFF_RESET, 32'h000000E0, OK);
		ticks(1);
		rd(`RAC_OFF_RESET, 32'h000000C0, OK);
		foreach (cmb[k]) begin
			wr(`RAC_OFF_PAGE, 8'h08 | {5'h00, cmb[k][0], 2'h0}, OK);
			wr(`RAC_OFF_RESET, {cmb[k][2:1], 6'h20}, OK);
			ticks(1);
			wr(`RAC_OFF_PAGE, 8'h88 | {5'h00, cmb[k][0], 2'h0}, OK);
			fall_cnt = 0;
			ticks(2060);
			chk_val(32'(fall_cnt), (cmb[k] == 3'b100) ? 32'h1 : 32'h0);
		end
		end_sim();
	end
endmodule : tb
